// ===== rtl/sram_ctl_pkg.sv
/*
 * Constants shared by the asynchronous static memory controller: pin widths,
 * timing figures in nanoseconds and the cycle counts derived from them.
 * Assumes a 50 MHz controller clock.
 */
package sram_ctl_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 32768;
	// Device timing figures, in nanoseconds.
	localparam int POWER_UP_WAIT_NS = 100000;
	localparam int WRITE_TO_HIGHZ_DELAY_NS = 5;
	localparam int DATA_SETUP_BEFORE_WRITE_END_NS = 6;
	localparam int WRITE_PULSE_NS = 7;
	localparam int READ_ACCESS_NS = 10;
	localparam int OUTPUT_OFF_NS = 5;
	localparam int DESELECT_TO_RETENTION_DELAY_NS = 0;
	// Least times round up and never fall below one cycle.
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int POWER_UP_WAIT_CYC = min_cycles(POWER_UP_WAIT_NS);
	localparam int HIGHZ_CYC = min_cycles(WRITE_TO_HIGHZ_DELAY_NS);
	localparam int SETUP_CYC = min_cycles(DATA_SETUP_BEFORE_WRITE_END_NS);
	localparam int WRITE_PULSE_CYC = min_cycles(WRITE_PULSE_NS) > HIGHZ_CYC + SETUP_CYC ?
		min_cycles(WRITE_PULSE_NS) : HIGHZ_CYC + SETUP_CYC;
	localparam int READ_CYC = min_cycles(READ_ACCESS_NS);
	localparam int TURN_CYC = min_cycles(OUTPUT_OFF_NS);
	localparam int RETENTION_CYC = min_cycles(DESELECT_TO_RETENTION_DELAY_NS);
	localparam int CNT_W = 13;
	localparam int PU_CNT_W = 17;
	typedef enum logic [2:0] {
		ST_POWER_UP, ST_IDLE, ST_WR_PULSE, ST_WR_END, ST_RD_WAIT, ST_RD_TURN, ST_RETAIN
	} ctl_state_e;
endpackage

// ===== rtl/sram_delay_cnt.sv
/*
 * Loadable down counter used for every wait of the memory controller.
 * Assumes the owner loads a count and watches the done flag.
 */
`timescale 1ns/1ns
`default_nettype none
module sram_delay_cnt #(
	parameter int W = 17
) (
	// Clock and control.
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Load and status.
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt_r;

	// Counts down to zero and then rests there.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (clk_en) begin
			if (load) begin
				cnt_r <= load_val;
			end else if (cnt_r != '0) begin
				cnt_r <= cnt_r - W'(1);
			end
		end
	end

	assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// ===== rtl/sram_ctl.sv
/*
 * Controller that drives an asynchronous 32K x 8 static memory through its
 * select, write strobe, output drive control, address and data pins.
 * One request is served at a time: a byte write, a byte read, or a stay in
 * data retention with the memory deselected.
 * Assumes pins are synchronous to core_clk, that a board-level tri-state buffer
 * joins data_lines_out, data_lines_oe and data_lines_in, and that the memory meets
 * the timing figures held in the package.
 */
// Contract
// - Controller holds write data stable across the ending strobe edge.
// - Strobe-ended write with drive low lasts high-z delay plus data setup.
// - Controller does not drive data while the device still drives them.
// - Controller keeps write strobe high for every read cycle.
// - Address is valid no later than select falling for reads.
// - Controller waits 100 microseconds after power up before any access.
// - Retention may follow deselect at once; select stays high throughout.
`timescale 1ns/1ns
`default_nettype none
module sram_ctl
	import sram_ctl_pkg::*;
#(
	parameter int POWER_UP_CYCLES = POWER_UP_WAIT_CYC
) (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// User request side.
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sram_ctl_pkg::ADDR_W-1:0] req_addr,
	input wire logic [sram_ctl_pkg::DATA_W-1:0] req_wdata,
	input wire logic retain_req,
	output logic req_ready,
	output logic rd_valid,
	output logic [sram_ctl_pkg::DATA_W-1:0] rd_data,
	output logic retaining,
	// Memory pins.
	output logic sel_n,
	output logic wr_strobe_n,
	output logic out_drive_n,
	output logic [sram_ctl_pkg::ADDR_W-1:0] addr_lines,
	input wire logic [sram_ctl_pkg::DATA_W-1:0] data_lines_in,
	output logic [sram_ctl_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe
);
	import sram_ctl_pkg::*;

	ctl_state_e state_r, state_nxt;
	logic wait_load;
	logic [PU_CNT_W-1:0] wait_val;
	logic wait_done;
	// Power-up bookkeeping and the load port shared with the state machine.
	logic pu_loaded_r;
	logic pu_pending;
	logic cnt_load;
	logic [PU_CNT_W-1:0] cnt_val;
	// A request is taken only from idle, and a retention request outranks it.
	logic take;

	// One counter covers power-up, write pulse, read access and turnaround.
	sram_delay_cnt #(
		.W(PU_CNT_W)
	) u_wait (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.load(cnt_load),
		.load_val(cnt_val),
		.done(wait_done)
	);

	// Accept strobe for the address and data capture; the state machine decodes the same terms itself.
	assign take = (state_r == ST_IDLE) && req_valid && !retain_req;

	// Next state; the power-up wait is loaded as reset releases.
	always_comb begin
		state_nxt = state_r;
		wait_load = 1'b0;
		wait_val = '0;
		case (state_r)
			ST_POWER_UP: begin
				// The counter still reads zero on the load cycle, so wait for the load first.
				if (wait_done && !pu_pending) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (retain_req) begin
					state_nxt = ST_RETAIN;
				end else if (req_valid && req_write) begin
					state_nxt = ST_WR_PULSE;
					wait_load = 1'b1;
					wait_val = PU_CNT_W'(WRITE_PULSE_CYC - 1);
				end else if (req_valid) begin
					state_nxt = ST_RD_WAIT;
					wait_load = 1'b1;
					wait_val = PU_CNT_W'(READ_CYC - 1);
				end
			end
			ST_WR_PULSE: begin
				if (wait_done) begin
					state_nxt = ST_WR_END;
				end
			end
			ST_WR_END: begin
				state_nxt = ST_IDLE;
			end
			ST_RD_WAIT: begin
				if (wait_done) begin
					state_nxt = ST_RD_TURN;
					wait_load = 1'b1;
					wait_val = PU_CNT_W'(TURN_CYC - 1);
				end
			end
			ST_RD_TURN: begin
				if (wait_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_RETAIN: begin
				if (!retain_req) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register; reset restarts the power-up wait.
	// A low clock enable freezes the state together with every other register.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= ST_POWER_UP;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Power-up load is a separate pulse so the counter starts full after reset.
	// Any reset, also one in mid-run, restarts the whole wait before the next access.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pu_loaded_r <= 1'b0;
		end else if (clk_en) begin
			pu_loaded_r <= 1'b1;
		end
	end
	// The load is pending on the first enabled cycle after reset.
	assign pu_pending = !pu_loaded_r;

	// Address and write data are latched on acceptance and held until the next one.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			addr_lines <= '0;
			data_lines_out <= '0;
		end else if (clk_en && take) begin
			addr_lines <= req_addr;
			data_lines_out <= req_wdata;
		end
	end

	// Strobes: in a write, select and write strobe fall and rise together, so each write ends on
	// one shared edge and the data outputs never get a chance to turn on between them.
	// The read turnaround state keeps the next write off the lines the memory drove.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sel_n <= 1'b1;
			wr_strobe_n <= 1'b1;
			out_drive_n <= 1'b1;
			data_lines_oe <= 1'b0;
		end else if (clk_en) begin
			sel_n <= !(state_nxt == ST_WR_PULSE || state_nxt == ST_RD_WAIT);
			wr_strobe_n <= !(state_nxt == ST_WR_PULSE);
			out_drive_n <= !(state_nxt == ST_RD_WAIT);
			// Data stays driven through the end cycle so it holds past the rising strobe.
			data_lines_oe <= (state_nxt == ST_WR_PULSE || state_nxt == ST_WR_END);
		end
	end

	// Read data is sampled in the last access cycle, while select is still low.
	// The byte is taken at the edge that raises select, before the outputs turn off.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else if (clk_en) begin
			rd_valid <= (state_r == ST_RD_WAIT && wait_done);
			if (state_r == ST_RD_WAIT && wait_done) begin
				rd_data <= data_lines_in;
			end
		end
	end

	// Status flags toward the user.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			req_ready <= 1'b0;
			retaining <= 1'b0;
		end else if (clk_en) begin
			req_ready <= (state_nxt == ST_IDLE) && !retain_req;
			retaining <= (state_nxt == ST_RETAIN);
		end
	end

	// The power-up load shares the counter load port with the state machine.
	// It never meets a state machine load, since the machine loads only from idle and read wait
	// and the first enabled cycle after reset always finds it in power-up.
	assign cnt_load = pu_pending ? 1'b1 : wait_load;
	assign cnt_val = pu_pending ? PU_CNT_W'(POWER_UP_CYCLES) : wait_val;
endmodule
`default_nettype wire

// ===== verif/sram_ctl_assertions.sv
/* Pin checker for the memory controller.
   Assumes binding to sram_ctl with clk_en high. */
`timescale 1ns/1ns
`default_nettype none
module sram_ctl_chk
	import sram_ctl_pkg::*;
(
	// Clock and user side.
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sram_ctl_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_ready,
	input wire logic retaining,
	// Memory pins.
	input wire logic sel_n,
	input wire logic wr_strobe_n,
	input wire logic out_drive_n,
	input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_lines,
	input wire logic [sram_ctl_pkg::DATA_W-1:0] data_lines_out,
	input wire logic data_lines_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Both strobes rise together, and the data drive is dropped one cycle later.
	sequence s_wr_end; $rose(wr_strobe_n) && $rose(sel_n); endsequence
	sequence s_oe_drop; data_lines_oe ##1 !data_lines_oe; endsequence
	property p_end; s_wr_end |-> s_oe_drop; endproperty
	property p_pulse; $fell(wr_strobe_n) |-> !wr_strobe_n [*2]; endproperty
	property p_hold; !sel_n && !wr_strobe_n |=> $stable(data_lines_out) && $stable(addr_lines);
	endproperty
	property p_rd_we; !out_drive_n |-> wr_strobe_n; endproperty
	property p_clash; data_lines_oe |-> out_drive_n; endproperty
	property p_pwr; $rose(reset_n) |-> (sel_n && !req_ready) [*8]; endproperty
	property p_ret; retaining |-> sel_n; endproperty
	property p_rd_addr;
		logic [ADDR_W-1:0] a;
		(clk_en && req_valid && req_ready && !req_write, a = req_addr) |=> !sel_n && addr_lines == a;
	endproperty
	a_end: assert property (p_end) else $error("write end wrong");
	a_pulse: assert property (p_pulse) else $error("write pulse short");
	a_hold: assert property (p_hold) else $error("write data moved");
	a_rd_we: assert property (p_rd_we) else $error("strobe low in read");
	a_clash: assert property (p_clash) else $error("data clash");
	a_pwr: assert property (p_pwr) else $error("early access");
	a_ret: assert property (p_ret) else $error("selected in retention");
	a_rd_addr: assert property (p_rd_addr) else $error("read address late");
endmodule
bind sram_ctl sram_ctl_chk u_chk(.core_clk, .reset_n, .clk_en, .req_valid, .req_write,
	.req_addr, .req_ready, .retaining, .sel_n, .wr_strobe_n, .out_drive_n, .addr_lines,
	.data_lines_out, .data_lines_oe);
`default_nettype wire

// ===== verif/sram_model.sv
/* Behavioural model of the static memory.
   Assumes the controller drives its pins directly. */
`timescale 1ns/1ns
`default_nettype none
module sram_model
	import sram_ctl_pkg::*;
(
	// Pins from the controller.
	input wire logic sel_n,
	input wire logic wr_strobe_n,
	input wire logic out_drive_n,
	input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_lines,
	input wire logic [sram_ctl_pkg::DATA_W-1:0] data_lines_out,
	input wire logic data_lines_oe,
	// Data back to the controller.
	output logic [sram_ctl_pkg::DATA_W-1:0] data_lines_in
);
	logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
	logic [DATA_W-1:0] bus_byte;
	// An undriven bus reads as the inverse, so a write without drive stores a wrong byte.
	assign bus_byte = data_lines_oe ? data_lines_out : ~data_lines_out;
	// Store during the overlap of both lows; the last value before either rises stays.
	always @(sel_n, wr_strobe_n, addr_lines, bus_byte)
		if (!sel_n && !wr_strobe_n) mem[addr_lines] = bus_byte;
	// Undriven lines show the inverse, so stale data never passes for a read.
	assign data_lines_in = (!sel_n && wr_strobe_n && !out_drive_n) ? mem[addr_lines] :
		~mem[addr_lines];
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/* Testbench for the memory controller.
   Assumes the checker is bound and the memory model stands at the pins. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import sram_ctl_pkg::*;
	logic core_clk = 0, reset_n = 0, clk_en = 1, req_valid = 0, req_write = 0, retain_req = 0;
	logic [ADDR_W-1:0] req_addr = '0, addr_lines;
	logic [DATA_W-1:0] req_wdata = '0, rd_data, data_lines_in, data_lines_out, e;
	logic req_ready, rd_valid, retaining, sel_n, wr_strobe_n, out_drive_n, data_lines_oe;
	logic [DATA_W-1:0] exp_q [$];
	logic [DATA_W-1:0] ref_m [int];
	int err_total = 0, checks = 0;
	localparam int PU_SIM = 10;
`define CHK(nm, x, g) begin checks++; if ((x) !== (g)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, x, g); end end
	// Clock at 50 MHz.
	initial forever #10 core_clk = ~core_clk;
	sram_ctl #(.POWER_UP_CYCLES(PU_SIM)) u_dut(.core_clk, .reset_n, .clk_en, .req_valid,
		.req_write, .req_addr, .req_wdata, .retain_req, .req_ready, .rd_valid, .rd_data,
		.retaining, .sel_n, .wr_strobe_n, .out_drive_n, .addr_lines, .data_lines_in,
		.data_lines_out, .data_lines_oe);
	sram_model u_mem(.sel_n, .wr_strobe_n, .out_drive_n, .addr_lines, .data_lines_out,
		.data_lines_oe, .data_lines_in);
	// Each read result is matched with the oldest note.
	always @(posedge core_clk) if (rd_valid === 1'b1) begin
		e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
		`CHK("rd_data", e, rd_data)
	end
	// One request, raised once the controller reads ready and held for one edge.
	task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		k = 0;
		do begin @(posedge core_clk); k++; end while (req_ready !== 1'b1 && k < 100);
		`CHK("req_ready", 1'b1, req_ready)
		req_valid <= 1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge core_clk);
		req_valid <= 0;
		if (w) ref_m[a] = d;
		else exp_q.push_back(ref_m[a]);
	endtask
	// Reset for two cycles, then count the cycles until the first access is allowed.
	task automatic pwr_wait;
		int k;
		reset_n <= 0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1;
		k = 0;
		do begin @(posedge core_clk); k++; end while (req_ready !== 1'b1 && k < 100);
		`CHK("power_wait", 1'b1, k >= PU_SIM && req_ready === 1'b1)
	endtask
	// Verdict, from the end of the tests or the watchdog.
	task close_out;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Cut a hang well past the hundred-odd cycles the tests need.
	initial begin #300000; err_total++; close_out; end
	initial begin
		void'($urandom(16));
		pwr_wait();
		// Corner and random places written, then read back to back.
		op(1, '0, 8'h5A);
		op(1, 15'h7FFF, 8'hA5);
		repeat (6) op(1, 15'($urandom), 8'($urandom));
		foreach (ref_m[a]) op(0, 15'(a), 8'h00);
		op(1, '0, 8'hC3);
		op(0, '0, 8'h00);
		// Retention keeps the memory deselected, then work resumes.
		retain_req <= 1;
		repeat (4) @(posedge core_clk);
		`CHK("retaining", 1'b1, retaining)
		`CHK("ret_sel", 1'b1, sel_n)
		// A frozen clock enable must hold retention although the request is gone.
		retain_req <= 0;
		clk_en <= 0;
		repeat (3) @(posedge core_clk);
		`CHK("ret_frozen", 1'b1, retaining)
		clk_en <= 1;
		// A reset in mid-run restarts the power-up wait; the memory keeps its bytes.
		pwr_wait();
		op(0, 15'h7FFF, 8'h00);
		repeat (10) @(posedge core_clk);
		`CHK("reads_left", 0, exp_q.size())
		close_out;
	end
endmodule
`default_nettype wire
